// File: src/brf_register_file.v
// Banked register file decode with control, stack and prime areas
`timescale 1ns/1ps
`default_nettype none
`include "brf_regs.vh"
module brf_register_file #(
  parameter DEPTH = `BRF_STORE_DEPTH
) (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Bank select operations from core
  input wire selectBankZeroOp,
  input wire selectBankOneOp,
  // Access request
  input wire accReq,
  input wire accWrite,
  input wire accPair,
  input wire [1:0] accMode,
  input wire [7:0] accAddr,
  input wire [15:0] accWrData,
  // Access answer
  output reg accRdValid,
  output reg [15:0] accRdData,
  output reg accError,
  // Visible state
  output wire bankSel,
  output wire [7:0] registerPageSelect,
  output wire [7:0] workingSlicePtrLo,
  output wire [7:0] workingSlicePtrHi
);
  // Sequencer states, one-hot
  localparam ST_IDLE = 3'b001;
  localparam ST_SECOND = 3'b010;
  localparam ST_DONE = 3'b100;

  // Control registers kept in flops
  reg bankSel_r;
  reg [7:0] pageSel_r;
  reg [7:0] sliceLo_r;
  reg [7:0] sliceHi_r;

  // Sequencer and pair bookkeeping
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg pairWr_r;
  reg [8:0] loLoc_r;
  reg [7:0] loWrData_r;
  reg regHit_r;
  reg [7:0] regData_r;
  reg isPair_r;
  reg [7:0] hiByte_r;

  // Decode results for the current request
  reg [7:0] effAddr;
  reg [8:0] loc;
  reg legal;
  reg [7:0] effLoAddr;
  reg [8:0] locLo;

  // Storage port signals
  reg ramWe;
  reg [8:0] ramWa;
  reg [7:0] ramWd;
  reg [8:0] ramRa;
  wire [7:0] ramRd;

  // Visible state straight from flops
  assign bankSel = bankSel_r;
  assign registerPageSelect = pageSel_r;
  assign workingSlicePtrLo = sliceLo_r;
  assign workingSlicePtrHi = sliceHi_r;

  // Working register number to real address via slice pointers
  function [7:0] workAddr;
    input [3:0] num;
    input [7:0] lo;
    input [7:0] hi;
    begin
      if (num[3])
        workAddr = {hi[7:3], num[2:0]};
      else
        workAddr = {lo[7:3], num[2:0]};
    end
  endfunction

  // Storage location for an address, mode and bank; only page 0 exists
  function [8:0] storeLoc;
    input [7:0] a;
    input [1:0] mode;
    input bank;
    begin
      // Stack set only for indirect and indexed modes in the upper range
      if (a < `BRF_CTRL_BASE)
        storeLoc = `BRF_STORE_PRIME + {1'b0, a};
      else if (mode == `BRF_MODE_INDIRECT || mode == `BRF_MODE_INDEXED)
        storeLoc = `BRF_STORE_STACK + {3'h0, a[5:0]};
      else if (a >= `BRF_BANKED_BASE && bank)
        storeLoc = `BRF_STORE_BANK1 + {4'h0, a[4:0]};
      else
        storeLoc = {1'b0, a};
    end
  endfunction

  // Whether the mode may reach this address
  // A pair never crosses a nibble, so the even byte decides for both
  function modeLegal;
    input [7:0] a;
    input [1:0] mode;
    begin
      if (a >= `BRF_CTRL_BASE && a < `BRF_SYS_BASE
          && mode == `BRF_MODE_DIRECT)
        modeLegal = 1'b0;
      else
        modeLegal = 1'b1;
    end
  endfunction

  // Address decode for first and paired bytes
  always @*
  begin
    if (accMode == `BRF_MODE_WORKING)
      effAddr = workAddr(accAddr[3:0], sliceLo_r, sliceHi_r);
    else
      effAddr = accAddr;
    if (accPair)
      effAddr = {effAddr[7:1], 1'b0};
    effLoAddr = {effAddr[7:1], 1'b1};
    loc = storeLoc(effAddr, accMode, bankSel_r);
    locLo = storeLoc(effLoAddr, accMode, bankSel_r);
    legal = modeLegal(effAddr, accMode);
  end

  // Control registers live in flops, not the memory
  function isCtrlReg;
    input [8:0] l;
    begin
      isCtrlReg = (l == {1'b0, `BRF_PAGE_SEL_ADDR})
        || (l == {1'b0, `BRF_SLICE_LO_ADDR})
        || (l == {1'b0, `BRF_SLICE_HI_ADDR});
    end
  endfunction

  // Read value of a control register location
  function [7:0] ctrlRead;
    input [8:0] l;
    input [7:0] pp;
    input [7:0] lo;
    input [7:0] hi;
    begin
      if (l == {1'b0, `BRF_PAGE_SEL_ADDR})
        ctrlRead = pp;
      else if (l == {1'b0, `BRF_SLICE_LO_ADDR})
        ctrlRead = lo;
      else
        ctrlRead = hi;
    end
  endfunction

  // Sequencer: pairs take two memory cycles
  always @*
  begin
    state_nxt = state_r;
    ramWe = 1'b0;
    ramWa = loc;
    ramWd = accWrData[15:8];
    ramRa = loc;
    case (state_r)
      ST_IDLE:
      begin
        if (accReq && legal)
        begin
          ramWe = accWrite && !isCtrlReg(loc);
          if (!accPair)
            ramWd = accWrData[7:0];
          state_nxt = accPair ? ST_SECOND : ST_DONE;
        end
        else if (accReq)
          state_nxt = ST_DONE;
      end
      ST_SECOND:
      begin
        ramWe = pairWr_r && !isCtrlReg(loLoc_r);
        ramWa = loLoc_r;
        ramWd = loWrData_r;
        ramRa = loLoc_r;
        state_nxt = ST_DONE;
      end
      // Requests seen here are ignored; the core waits for the answer
      ST_DONE:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Storage for all mapped bytes except the control registers
  brf_store_ram #(.AW(9), .DEPTH(DEPTH)) u_store (
    .clk_sys(clk_sys),
    .wrEn(ramWe),
    .wrAddr(ramWa),
    .wrData(ramWd),
    .rdAddr(ramRa),
    .rdData(ramRd)
  );

  // State, control registers and answer
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      // Memory contents are not cleared; only flops reset
      state_r <= ST_IDLE;
      bankSel_r <= 1'b0;
      pageSel_r <= `BRF_PAGE_SEL_RST;
      sliceLo_r <= `BRF_SLICE_LO_RST;
      sliceHi_r <= `BRF_SLICE_HI_RST;
      pairWr_r <= 1'b0;
      loLoc_r <= 9'h000;
      loWrData_r <= 8'h00;
      regHit_r <= 1'b0;
      regData_r <= 8'h00;
      isPair_r <= 1'b0;
      hiByte_r <= 8'h00;
      accRdValid <= 1'b0;
      accRdData <= 16'h0000;
      accError <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      accRdValid <= 1'b0;
      accError <= 1'b0;
      // Bank select ops; bank one wins if both
      if (selectBankOneOp)
        bankSel_r <= 1'b1;
      else if (selectBankZeroOp)
        bankSel_r <= 1'b0;
      // Take a request; a refused one answers zero with an error pulse
      if (state_r == ST_IDLE && accReq)
      begin
        isPair_r <= accPair;
        pairWr_r <= accWrite && accPair && legal;
        loLoc_r <= locLo;
        loWrData_r <= accWrData[7:0];
        regHit_r <= isCtrlReg(loc);
        regData_r <= ctrlRead(loc, pageSel_r, sliceLo_r, sliceHi_r);
        accError <= 1'b0;
        if (!legal)
        begin
          accError <= 1'b1;
          regHit_r <= 1'b1;
          regData_r <= 8'h00;
          isPair_r <= 1'b0;
        end
        else if (accWrite)
        begin
          // Single write, or high byte of pair, to control registers
          if (loc == {1'b0, `BRF_PAGE_SEL_ADDR})
            pageSel_r <= accPair ? accWrData[15:8] : accWrData[7:0];
          if (loc == {1'b0, `BRF_SLICE_LO_ADDR})
            sliceLo_r <= accPair ? accWrData[15:8] : accWrData[7:0];
          if (loc == {1'b0, `BRF_SLICE_HI_ADDR})
            sliceHi_r <= accPair ? accWrData[15:8] : accWrData[7:0];
        end
      end
      if (state_r == ST_SECOND)
      begin
        hiByte_r <= regHit_r ? regData_r : ramRd;
        regHit_r <= isCtrlReg(loLoc_r);
        regData_r <= ctrlRead(loLoc_r, pageSel_r, sliceLo_r, sliceHi_r);
        // Odd byte of a pair write may land on a control register
        if (pairWr_r && loLoc_r == {1'b0, `BRF_SLICE_HI_ADDR})
          sliceHi_r <= loWrData_r;
        if (pairWr_r && loLoc_r == {1'b0, `BRF_PAGE_SEL_ADDR})
          pageSel_r <= loWrData_r;
      end
      // One-cycle answer, data from flops or the memory
      if (state_r == ST_DONE)
      begin
        accRdValid <= 1'b1;
        if (isPair_r)
          accRdData <= {hiByte_r, regHit_r ? regData_r : ramRd};
        else
          accRdData <= {8'h00, regHit_r ? regData_r : ramRd};
      end
    end
  end
  // Page select value never alters decode: page 0 always
endmodule
`default_nettype wire

// File: src/brf_regs.vh
// Register file address map, field positions and reset values
`ifndef BRF_REGS_VH
`define BRF_REGS_VH
`define BRF_CTRL_BASE 8'hc0
`define BRF_BANKED_BASE 8'he0
`define BRF_SYS_BASE 8'hd0
`define BRF_PAGE_SEL_ADDR 8'hdf
`define BRF_SLICE_LO_ADDR 8'hd6
`define BRF_SLICE_HI_ADDR 8'hd7
`define BRF_PAGE_SEL_RST 8'h00
`define BRF_SLICE_LO_RST 8'hc0
`define BRF_SLICE_HI_RST 8'hc8
`define BRF_PAGE_DST_MSB 7
`define BRF_PAGE_DST_LSB 4
`define BRF_PAGE_SRC_MSB 3
`define BRF_PAGE_SRC_LSB 0
`define BRF_MODE_DIRECT 2'h0
`define BRF_MODE_WORKING 2'h1
`define BRF_MODE_INDIRECT 2'h2
`define BRF_MODE_INDEXED 2'h3
`define BRF_STORE_PRIME 9'h000
`define BRF_STORE_CTRL 9'h0c0
`define BRF_STORE_BANK1 9'h100
`define BRF_STORE_STACK 9'h120
`define BRF_STORE_DEPTH 352
`endif

// File: src/brf_store_ram.v
// Byte storage memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module brf_store_ram #(
  parameter AW = 9,
  parameter DEPTH = 352
) (
  // Clock
  input wire clk_sys,
  // Write port
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [7:0] wrData,
  // Read port
  input wire [AW-1:0] rdAddr,
  output reg [7:0] rdData
);
  reg [7:0] mem [0:DEPTH-1];

  // One write and one registered read per cycle
  always @(posedge clk_sys)
  begin
    if (wrEn)
      mem[wrAddr] <= wrData;
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// File: tb/brf_props.sv
// Port assertions for the banked register file
`timescale 1ns/1ps
`default_nettype none
module brf_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Requests
  input wire logic selectBankZeroOp,
  input wire logic selectBankOneOp,
  input wire logic accReq,
  input wire logic accPair,
  input wire logic [1:0] accMode,
  input wire logic [7:0] accAddr,
  // Answers and state
  input wire logic accRdValid,
  input wire logic [15:0] accRdData,
  input wire logic accError,
  input wire logic bankSel,
  input wire logic [7:0] registerPageSelect,
  input wire logic [7:0] workingSlicePtrLo
);
  logic busy_r;
  logic pair_r;
  wire take = accReq && !busy_r;
  wire bad = accMode == 2'h0 && accAddr[7:4] == 4'hc;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Tracks the access in flight
  always_ff @(posedge clk_sys)
  begin
    busy_r <= sys_rst || accRdValid ? 1'b0 : take ? 1'b1 : busy_r;
    pair_r <= take ? accPair : pair_r;
  end
  sequence s_wait;
    !accRdValid;
  endsequence
  a_single_ans: assert property (take && (!accPair || bad) |->
    ##1 s_wait ##1 accRdValid) else $error("single answer late");
  a_pair_ans: assert property (take && accPair && !bad |->
    ##1 s_wait [*2] ##1 accRdValid) else $error("pair answer late");
  a_direct_err: assert property (take && bad |=> accError)
    else $error("direct common access not refused");
  a_legal_ok: assert property (take && !bad |=> !accError)
    else $error("legal access refused");
  a_err_zero: assert property (accRdValid &&
    ($past(accError) || $past(accError, 2)) |-> accRdData == 16'h0000)
    else $error("refused read data not zero");
  a_byte_hi: assert property (accRdValid && !pair_r |->
    accRdData[15:8] == 8'h00) else $error("single read high byte");
  a_bank_one: assert property (selectBankOneOp |=> bankSel)
    else $error("bank one not taken");
  a_bank_zero: assert property (selectBankZeroOp && !selectBankOneOp |=>
    !bankSel) else $error("bank zero not taken");
  a_bank_keep: assert property (!selectBankZeroOp && !selectBankOneOp
    |=> $stable(bankSel)) else $error("bank moved alone");
  a_reset_vals: assert property ($fell(sys_rst) |-> !bankSel &&
    registerPageSelect == 8'h00 && workingSlicePtrLo == 8'hc0)
    else $error("reset state wrong");
endmodule
bind brf_register_file brf_chk brf_chk_inst (.clk_sys, .sys_rst,
  .selectBankZeroOp, .selectBankOneOp, .accReq, .accPair, .accMode,
  .accAddr, .accRdValid, .accRdData, .accError, .bankSel,
  .registerPageSelect, .workingSlicePtrLo);
`default_nettype wire

// File: tb/brf_core.sv
// Core model issuing accesses and bank selects
`timescale 1ns/1ps
`default_nettype none
module brf_core (
  // Clock
  input wire logic clk_sys,
  // Bank select pulses
  output logic selectBankZeroOp,
  output logic selectBankOneOp,
  // Access request
  output logic accReq,
  output logic accWrite,
  output logic accPair,
  output logic [1:0] accMode,
  output logic [7:0] accAddr,
  output logic [15:0] accWrData,
  // Access answer
  input wire logic accRdValid,
  input wire logic [15:0] accRdData,
  input wire logic accError
);
  // Idle drive from time zero
  initial
    {selectBankZeroOp, selectBankOneOp, accReq, accWrite, accPair,
      accMode, accAddr, accWrData} = '0;
  // One-cycle bank pulse; bank one wins when both are set
  task automatic sel(input logic one, both);
    @(posedge clk_sys);
    #1 {selectBankOneOp, selectBankZeroOp} = {one, !one || both};
    @(posedge clk_sys);
    #1 {selectBankOneOp, selectBankZeroOp} = 2'b00;
  endtask
  // Pulse the request, hold its fields until the answer edge
  task automatic acc(input logic w, p, input logic [1:0] m,
    input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] q, output logic e, ok);
    int n;
    e = 1'b0;
    ok = 1'b0;
    @(posedge clk_sys);
    #1 {accReq, accWrite, accPair, accMode, accAddr, accWrData} =
      {1'b1, w, p, m, a, d};
    @(posedge clk_sys);
    #1 accReq = 1'b0;
    for (n = 0; n < 8 && !ok; n++)
    begin
      e = e | accError;
      ok = accRdValid;
      if (!ok)
        @(posedge clk_sys) #1;
    end
    q = accRdData;
    @(posedge clk_sys);
    // Released address and write data no longer show the old value
    #1 accAddr = ~a;
    accWrData = ~d;
  endtask
endmodule
`default_nettype wire

// File: tb/banked_register_file_decode_tb_top.sv
// Self-checking bench for the banked register file
`timescale 1ns/1ps
`default_nettype none
module banked_register_file_decode_tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic accReq, accWrite, accPair, selectBankZeroOp, selectBankOneOp;
  logic accRdValid, accError, bankSel;
  logic [1:0] accMode;
  logic [7:0] accAddr, registerPageSelect;
  logic [7:0] workingSlicePtrLo, workingSlicePtrHi;
  logic [15:0] accWrData, accRdData;
  int fails = 0;
  int check_count = 0;
  int seed = 32'hb1b67427;
  int bnk = 0;
  int mem [0:351];
  // Clock at 200 MHz
  initial
    forever #2.5 clk_sys = ~clk_sys;
  // Design and core model
  brf_register_file brf_register_file_inst (.clk_sys, .sys_rst,
    .selectBankZeroOp, .selectBankOneOp, .accReq, .accWrite, .accPair,
    .accMode, .accAddr, .accWrData, .accRdValid, .accRdData, .accError,
    .bankSel, .registerPageSelect, .workingSlicePtrLo, .workingSlicePtrHi);
  brf_core core (.clk_sys, .selectBankZeroOp, .selectBankOneOp, .accReq,
    .accWrite, .accPair, .accMode, .accAddr, .accWrData, .accRdValid,
    .accRdData, .accError);
  // Working mode goes through a slice pointer
  function automatic int eff(input int a, m);
    return m == 1 ? mem[a[3] ? 8'hd7 : 8'hd6] & 8'hf8 | a & 7 : a;
  endfunction
  // Storage slot: stack for indirect or indexed, bank 1 from e0h up
  function automatic int loc(input int a, m);
    return a < 8'hc0 ? a : m > 1 ? a + 8'h60 : a >= 8'he0 && bnk ? a + 8'h20 : a;
  endfunction
  task automatic cmp(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset for 10 cycles and reset the model
  task automatic rst;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    foreach (mem[i]) mem[i] = -1;
    mem[8'hd6] = 8'hc0;
    mem[8'hd7] = 8'hc8;
    mem[8'hdf] = 0;
    bnk = 0;
  endtask
  // One access checked against the model
  task automatic run(input logic w, p, input logic [1:0] m,
    input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic e, ok;
    int x, hi, lo, bad;
    x = eff(p ? a & 8'hfe : a, m);
    hi = loc(x, m);
    lo = loc(x + 1, m);
    bad = m == 0 && x >> 4 == 12;
    @(posedge clk_sys);
    #1 cmp(bankSel, bnk);
    cmp(registerPageSelect, mem[8'hdf]);
    cmp(workingSlicePtrLo, mem[8'hd6]);
    cmp(workingSlicePtrHi, mem[8'hd7]);
    core.acc(w, p, m, a, d, q, e, ok);
    cmp(ok, 1);
    cmp(e, bad);
    if (!w && bad)
      cmp(q, 0);
    else if (!w && mem[hi] >= 0 && (!p || mem[lo] >= 0))
      cmp(q, p ? {mem[hi][7:0], mem[lo][7:0]} : mem[hi]);
    else if (w && !bad)
    begin
      mem[hi] = p ? d[15:8] : d[7:0];
      if (p)
        mem[lo] = d[7:0];
    end
  endtask
  // Hang guard
  initial
  begin
    #100000;
    fails++;
    test_done();
  end
  // Main sequence
  initial
  begin
    logic [31:0] r;
    int i;
    rst();
    run(1, 0, 3, 8'h00, 16'h5a);
    run(0, 0, 2, 8'h00, 0);
    run(0, 0, 0, 8'hdf, 0);
    core.sel(1, 1);
    bnk = 1;
    for (i = 0; i < 400; i++)
    begin
      r = $random(seed);
      if (r[3:0] == 0)
      begin
        core.sel(r[4], r[5]);
        bnk = r[4];
      end
      run(r[24], r[7] && r[9:8] != 1, r[9:8],
        r[6] ? {2'b11, r[15:10]} : r[23:16], r[31:16]);
    end
    rst();
    run(0, 0, 0, 8'hd7, 0);
    test_done();
  end
endmodule
`default_nettype wire
